/* rtl/ranging_host_ctrl.sv */
// Host side controller of the ranging sensor's two-wire target port.
// Assumes open-drain pads with pull-ups outside and a same-clock user port.
`timescale 1ns/100ps
`include "host_consts.svh"

module ranging_host_ctrl #(
  parameter int QTR = `QTR_CYC,
  parameter int PRST = `PRST_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic req_valid,
  input host_pkg::xfer_req_t req,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic comms_enable,
  input wire logic port_reset_req,
  input wire logic sda_i,
  output logic req_ready,
  output logic wr_taken,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic xfer_done,
  output logic xfer_nack,
  output logic scl_o,
  output logic scl_oe_n,
  output logic sda_o,
  output logic sda_oe_n,
  output logic port_rst,
  output logic low_power_comms_gate
);
  host_pkg::top_state_t fsm_q;
  host_pkg::top_state_t fsm_d;
  host_pkg::xfer_req_t req_q;
  host_pkg::bus_cmd_t cmd;
  logic [7:0] cnt_q;
  logic [7:0] rd_data_q;
  logic [15:0] prst_cnt_q;
  logic [15:0] prst_len_q;
  logic pend_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic line_lo_q;
  logic req_ready_q;
  logic wr_taken_q;
  logic rd_valid_q;
  logic done_q;
  logic nack_q;
  logic prst_q;
  logic gate_q;
  logic eng_ready;
  logic eng_done;
  logic eng_ackn;
  logic [7:0] eng_byte;

  // State decode
  wire s_idle = fsm_q == host_pkg::T_IDLE;
  wire s_prst = fsm_q == host_pkg::T_PRST;
  wire s_start = fsm_q == host_pkg::T_START;
  wire s_addrw = fsm_q == host_pkg::T_ADDRW;
  wire s_idxh = fsm_q == host_pkg::T_IDXH;
  wire s_idxl = fsm_q == host_pkg::T_IDXL;
  wire s_wdat = fsm_q == host_pkg::T_WDAT;
  wire s_rstart = fsm_q == host_pkg::T_RSTART;
  wire s_addrr = fsm_q == host_pkg::T_ADDRR;
  wire s_rdat = fsm_q == host_pkg::T_RDAT;
  wire s_stop = fsm_q == host_pkg::T_STOP;

  wire take_req = req_valid && req_ready_q;
  wire busy = !s_idle && !s_prst;
  // A write data byte is only sent once the user offers it
  wire cmd_valid = busy && !pend_q && (!s_wdat || wr_valid);
  wire issue = cmd_valid && eng_ready;
  // Only bytes this side sent carry a target acknowledge
  wire tx_state = s_addrw || s_idxh || s_idxl || s_wdat || s_addrr;
  wire ok = eng_done && !eng_ackn;
  wire nak = eng_done && eng_ackn && tx_state;
  wire last_byte = cnt_q == 8'h01;
  wire no_data = cnt_q == 8'h00;
  wire prst_end = prst_cnt_q == 16'(PRST - 1);

  // Command presented to the bit engine in each state
  always_comb begin
    cmd.op = host_pkg::OP_WRITE;
    cmd.byte_v = 8'h00;
    cmd.ack_n = 1'b1;
    case (fsm_q)
      host_pkg::T_START, host_pkg::T_RSTART: begin
        cmd.op = host_pkg::OP_START;
      end
      host_pkg::T_ADDRW: begin
        cmd.byte_v = `ADDR_WR;
      end
      host_pkg::T_ADDRR: begin
        cmd.byte_v = `ADDR_RD;
      end
      host_pkg::T_IDXH: begin
        cmd.byte_v = req_q.index[15:8];
      end
      host_pkg::T_IDXL: begin
        cmd.byte_v = req_q.index[7:0];
      end
      host_pkg::T_WDAT: begin
        cmd.byte_v = wr_data;
      end
      host_pkg::T_RDAT: begin
        cmd.op = host_pkg::OP_READ;
        cmd.ack_n = last_byte;
      end
      host_pkg::T_STOP: begin
        cmd.op = host_pkg::OP_STOP;
      end
      default: begin
        cmd.op = host_pkg::OP_STOP;
      end
    endcase
  end

  // Message sequencer
  always_comb begin
    fsm_d = fsm_q;
    case (fsm_q)
      host_pkg::T_IDLE: begin
        if (take_req) begin
          fsm_d = host_pkg::T_START;
        end else if (port_reset_req) begin
          fsm_d = host_pkg::T_PRST;
        end
      end
      host_pkg::T_PRST: begin
        if (prst_end) begin
          fsm_d = host_pkg::T_IDLE;
        end
      end
      host_pkg::T_START: begin
        if (eng_done) begin
          fsm_d = host_pkg::T_ADDRW;
        end
      end
      host_pkg::T_ADDRW: begin
        if (nak) begin
          fsm_d = host_pkg::T_STOP;
        end else if (ok) begin
          fsm_d = host_pkg::T_IDXH;
        end
      end
      host_pkg::T_IDXH: begin
        if (nak) begin
          fsm_d = host_pkg::T_STOP;
        end else if (ok) begin
          fsm_d = host_pkg::T_IDXL;
        end
      end
      // Read goes on with repeated start
      host_pkg::T_IDXL: begin
        if (nak) begin
          fsm_d = host_pkg::T_STOP;
        end else if (ok && req_q.rd) begin
          fsm_d = host_pkg::T_RSTART;
        end else if (ok) begin
          fsm_d = no_data ? host_pkg::T_STOP : host_pkg::T_WDAT;
        end
      end
      host_pkg::T_WDAT: begin
        if (nak || (ok && last_byte)) begin
          fsm_d = host_pkg::T_STOP;
        end
      end
      host_pkg::T_RSTART: begin
        if (eng_done) begin
          fsm_d = host_pkg::T_ADDRR;
        end
      end
      host_pkg::T_ADDRR: begin
        if (nak) begin
          fsm_d = host_pkg::T_STOP;
        end else if (ok) begin
          fsm_d = no_data ? host_pkg::T_STOP : host_pkg::T_RDAT;
        end
      end
      host_pkg::T_RDAT: begin
        if (eng_done && last_byte) begin
          fsm_d = host_pkg::T_STOP;
        end
      end
      host_pkg::T_STOP: begin
        if (eng_done) begin
          fsm_d = host_pkg::T_IDLE;
        end
      end
      default: begin
        fsm_d = host_pkg::T_IDLE;
      end
    endcase
  end

  // Pad input crosses into mclk through two flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else if (ce) begin
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fsm_q <= host_pkg::T_IDLE;
      req_q <= '0;
      cnt_q <= 8'h00;
      pend_q <= 1'b0;
    end else if (ce) begin
      fsm_q <= fsm_d;
      if (issue) begin
        pend_q <= 1'b1;
      end else if (eng_done) begin
        pend_q <= 1'b0;
      end
      if (take_req) begin
        req_q <= req;
        cnt_q <= req.len;
      end else if (eng_done && (s_wdat || s_rdat)) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // User side strobes and status
  always_ff @(posedge mclk) begin
    if (reset) begin
      req_ready_q <= 1'b0;
      wr_taken_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (ce) begin
      req_ready_q <= fsm_d == host_pkg::T_IDLE && comms_enable;
      wr_taken_q <= issue && s_wdat;
      rd_valid_q <= eng_done && s_rdat;
      if (eng_done && s_rdat) begin
        rd_data_q <= eng_byte;
      end
      done_q <= eng_done && s_stop;
      if (nak) begin
        nack_q <= 1'b1;
      end else if (take_req) begin
        nack_q <= 1'b0;
      end
    end
  end

  // Side pins: comms gate and port reset pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      gate_q <= `GATE_RST;
      prst_q <= 1'b0;
      prst_cnt_q <= 16'h0000;
      line_lo_q <= 1'b0;
    end else if (ce) begin
      gate_q <= comms_enable;
      prst_q <= fsm_d == host_pkg::T_PRST;
      prst_cnt_q <= s_prst ? prst_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  bus_bit_engine #(
    .QTR(QTR)
  ) u_engine (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .sda_in(sda_s2_q),
    .cmd_ready(eng_ready),
    .done(eng_done),
    .rx_byte(eng_byte),
    .rx_ack_n(eng_ackn),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n)
  );

  assign req_ready = req_ready_q;
  assign wr_taken = wr_taken_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign xfer_done = done_q;
  assign xfer_nack = nack_q;
  assign scl_o = line_lo_q;
  assign sda_o = line_lo_q;
  assign port_rst = prst_q;
  assign low_power_comms_gate = gate_q;

  // Helper: length of the port reset pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      prst_len_q <= 16'h0000;
    end else if (ce) begin
      prst_len_q <= prst_q ? prst_len_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  addr_byte_a: assert property (
    issue && (s_addrw || s_addrr) |-> cmd.byte_v == (req_q.rd && s_addrr ? `ADDR_RD : `ADDR_WR))
    else $error("wrong target address byte");
  idx_order_a: assert property (
    s_idxh && ok |=> s_idxl ##0 (!issue || cmd.byte_v == req_q.index[7:0]))
    else $error("index bytes out of order");
  rep_start_a: assert property (
    s_idxl && ok && req_q.rd |=> s_rstart && !done_q)
    else $error("read did not use repeated start");
  rd_ack_a: assert property (issue && s_rdat && !last_byte |-> !cmd.ack_n)
    else $error("read byte not acknowledged");
  rd_end_a: assert property (
    s_rdat && eng_done && last_byte |-> eng_ackn ##1 s_stop)
    else $error("last read not followed by stop");
  wr_nak_a: assert property (nak |=> s_stop ##1 !wr_taken_q)
    else $error("refused byte did not end message");
  idle_lines_a: assert property (s_idle && !pend_q |-> scl_oe_n && sda_oe_n)
    else $error("bus not released in idle");
  gate_ref_a: assert property (!gate_q |-> !req_ready_q)
    else $error("request offered while comms gated");
  prst_pulse_a: assert property ($fell(prst_q) |-> $past(prst_len_q) == 16'(PRST - 1))
    else $error("port reset pulse width wrong");

endmodule

/* rtl/host_consts.svh */
// Constants for the two-wire host controller of the ranging sensor.
// Assumes a 40 MHz mclk; all counts derive from the times below.
`ifndef HOST_CONSTS_SVH
`define HOST_CONSTS_SVH

// Clock period and least serial bit time, in ns
`define MCLK_NS 25
`define BIT_NS 1000
// Quarter bit in mclk cycles, rounded up so the rate never exceeds the limit
`define QTR_CYC ((`BIT_NS + 4 * `MCLK_NS - 1) / (4 * `MCLK_NS))
// Port reset pulse width, in ns and in cycles
`define PRST_NS 1000
`define PRST_CYC ((`PRST_NS + `MCLK_NS - 1) / `MCLK_NS)

// Target address bytes
`define ADDR_WR 8'h52
`define ADDR_RD 8'h53

// Bit slot of the acknowledge and quarter phases of a bit
`define ACK_SLOT 4'h8
`define NINE_CLK 4'h9
`define PH_FALL 2'h0
`define PH_SAMPLE 2'h2
`define PH_EDGE 2'h3

// Reset level of the comms gate pin (enabled)
`define GATE_RST 1'b1

`endif

/* rtl/host_pkg.sv */
// Types shared by the two-wire host controller and its bit engine.
// Assumes nothing of its surroundings.
package host_pkg;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ = 2'h3
  } bus_op_t;

  typedef struct packed {
    bus_op_t op;
    logic [7:0] byte_v;
    logic ack_n;
  } bus_cmd_t;

  typedef struct packed {
    logic rd;
    logic [15:0] index;
    logic [7:0] len;
  } xfer_req_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h1,
    E_RUN = 2'h2
  } eng_state_t;

  typedef enum logic [10:0] {
    T_IDLE = 11'h001,
    T_PRST = 11'h002,
    T_START = 11'h004,
    T_ADDRW = 11'h008,
    T_IDXH = 11'h010,
    T_IDXL = 11'h020,
    T_WDAT = 11'h040,
    T_RSTART = 11'h080,
    T_ADDRR = 11'h100,
    T_RDAT = 11'h200,
    T_STOP = 11'h400
  } top_state_t;

endpackage

/* rtl/bus_bit_engine.sv */
// Bit sequencer of a two-wire bus controller: start, stop, byte write, byte read.
// Assumes sda_in is already synchronised to mclk and no target stretches the clock.
`timescale 1ns/100ps
`include "host_consts.svh"
module bus_bit_engine #(
  parameter int QTR = `QTR_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input host_pkg::bus_cmd_t cmd,
  input wire logic sda_in,
  output logic cmd_ready,
  output logic done,
  output logic [7:0] rx_byte,
  output logic rx_ack_n,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  host_pkg::eng_state_t fsm_q;
  host_pkg::bus_op_t op_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic ackn_q;
  logic rxack_q;
  logic scl_q;
  logic sda_q;
  logic done_q;
  logic [7:0] hi_cnt_q;
  logic [3:0] rise_cnt_q;

  wire run = fsm_q == host_pkg::E_RUN;
  wire accept = fsm_q == host_pkg::E_IDLE && cmd_valid;
  // Quarter count paces the bit rate
  wire step = run && qcnt_q == 8'(QTR - 1);
  wire is_rd = op_q == host_pkg::OP_READ;
  wire is_byte = is_rd || op_q == host_pkg::OP_WRITE;
  wire ack_slot = bit_q == `ACK_SLOT;
  // Receiver releases data bits; the sender releases the acknowledge slot
  wire byte_sda = ack_slot ? (!is_rd || ackn_q) : (is_rd || tx_q[7]);
  // Start and stop edges
  // Start falls and stop rises in the last quarter, with the clock high
  wire cond_sda = (ph_q == `PH_EDGE) == (op_q == host_pkg::OP_STOP);
  // Data held through the falling quarter
  wire sda_lvl = ph_q == `PH_FALL ? sda_q : (is_byte ? byte_sda : cond_sda);
  wire last = step && ph_q == `PH_EDGE && (!is_byte || ack_slot);

  assign cmd_ready = fsm_q == host_pkg::E_IDLE;
  assign done = done_q;
  assign rx_byte = rx_q;
  assign rx_ack_n = rxack_q;
  assign scl_oe_n = scl_q;
  assign sda_oe_n = sda_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      fsm_q <= host_pkg::E_IDLE;
      op_q <= host_pkg::OP_START;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      qcnt_q <= 8'h00;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      ackn_q <= 1'b1;
      rxack_q <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= last;
      if (accept) begin
        fsm_q <= host_pkg::E_RUN;
        op_q <= cmd.op;
        tx_q <= cmd.byte_v;
        ackn_q <= cmd.ack_n;
        qcnt_q <= 8'h00;
        ph_q <= 2'h0;
        bit_q <= 4'h0;
      end else if (run) begin
        qcnt_q <= step ? 8'h00 : qcnt_q + 8'h01;
        scl_q <= ph_q[1];
        sda_q <= sda_lvl;
        if (step) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == `PH_SAMPLE && is_byte && !ack_slot) begin
            rx_q <= {rx_q[6:0], sda_in};
          end
          if (ph_q == `PH_SAMPLE && is_byte && ack_slot) begin
            rxack_q <= sda_in;
          end
          if (ph_q == `PH_EDGE) begin
            bit_q <= bit_q + 4'h1;
            tx_q <= {tx_q[6:0], 1'b0};
          end
          if (last) begin
            fsm_q <= host_pkg::E_IDLE;
          end
        end
      end
    end
  end

  // Helper counters for the checks below
  always_ff @(posedge mclk) begin
    if (reset) begin
      hi_cnt_q <= 8'h00;
      rise_cnt_q <= 4'h0;
    end else if (ce) begin
      hi_cnt_q <= !scl_q ? 8'h00 : (hi_cnt_q == 8'hFF ? hi_cnt_q : hi_cnt_q + 8'h01);
      if (accept) begin
        rise_cnt_q <= 4'h0;
      end else if (scl_q && !$past(scl_q)) begin
        rise_cnt_q <= rise_cnt_q + 4'h1;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  scl_high_a: assert property ($fell(scl_q) |-> hi_cnt_q >= 8'(2 * QTR))
    else $error("clock high shorter than half a bit");
  sda_hold_a: assert property (
    run && is_byte && scl_q && $past(scl_q) |-> $stable(sda_q))
    else $error("data moved while clock high");
  cond_only_a: assert property (
    $changed(sda_q) && scl_q && $past(scl_q) |-> run && !is_byte)
    else $error("data edge in clock high outside start or stop");
  nine_clk_a: assert property (done_q && is_byte |-> rise_cnt_q == `NINE_CLK)
    else $error("byte did not take nine clocks");

endmodule

/* test/sensor_target_model.sv */
// Behavioural model of the ranging sensor's serial target port.
// Assumes the bench resolves both open-drain wires and feeds them back.
`timescale 1ns/100ps
module sensor_target_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic gate,
  input wire logic port_rst,
  input wire logic refuse,
  output logic pull,
  output logic [15:0] idx
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] tx;
  logic active;
  logic rw;
  logic ack;
  logic ranging;
  int bitn;
  int byten;

  // Powers up in active idle; ranging, emitter pulsing, is never entered here
  initial begin
    ranging = 1'b0;
    pull = 1'b0;
    active = 1'b0;
    rw = 1'b0;
    idx = 16'h0;
    tx = 8'h0;
  end

  task automatic byte_in();
    begin
      ack = 1'b1;
      if (byten == 0) begin
        ack = (sh[7:1] == 7'h29);
        rw = sh[0];
      end else if (byten < 3) begin
        idx = (byten == 1) ? {sh, idx[7:0]} : {idx[15:8], sh};
      end else if (refuse) begin
        ack = 1'b0;
      end else begin
        mem[idx[7:0]] = sh;
        idx = idx + 16'h1;
      end
    end
  endtask

  // Start opens a message only with the gate high
  always @(negedge sda) begin
    if (scl === 1'b1 && gate === 1'b1) begin
      active = 1'b1;
      bitn = 0;
      byten = 0;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
      pull = 1'b0;
    end
  end

  // Sample on rising clock; a refused byte ends the message
  always @(posedge scl) begin
    if (active) begin
      if (bitn < 8) begin
        sh = {sh[6:0], sda};
      end
      if (bitn == 7 && !(rw && byten > 0)) begin
        byte_in();
      end
      if (bitn == 8 && ((rw && byten > 0) ? sda : !ack)) begin
        active = 1'b0;
      end
      bitn = (bitn == 8) ? 0 : bitn + 1;
      byten = (bitn == 0) ? byten + 1 : byten;
    end
  end

  // Load current register, drive after falling clock
  always @(negedge scl) begin
    if (active && bitn == 0 && rw && byten > 0) begin
      tx = mem[idx[7:0]];
      idx = idx + 16'h1;
    end
    if (active) begin
      pull = (bitn == 8) ? (ack && !(rw && byten > 0)) : (rw && byten > 0 && !tx[7 - bitn]);
    end
  end

  // End of the port reset pulse clears the serial state only
  always @(negedge port_rst) begin
    active = 1'b0;
    pull = 1'b0;
  end
endmodule

/* test/ranging_host_ctrl_bench.sv */
// Self-checking bench of the two-wire host controller against a target model.
// Assumes rtl/ sources compiled first; pull-ups are modelled by ANDing the host release with the inverted target pull.
`timescale 1ns/100ps
module ranging_host_ctrl_bench;
  localparam int PRST_T = 8;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  host_pkg::xfer_req_t req = '0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h0;
  logic comms_enable = 1'b1;
  logic port_reset_req = 1'b0;
  logic ce = 1'b1;
  logic refuse = 1'b0;
  logic req_ready, wr_taken, rd_valid, xfer_done, xfer_nack;
  logic scl_oe_n, sda_oe_n, port_rst, low_power_comms_gate, t_pull;
  logic [7:0] rd_data;
  logic scl_o, sda_o;
  logic [15:0] idx_m;
  wire logic scl_w = scl_oe_n;
  wire logic sda_w = sda_oe_n & ~t_pull;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int starts = 0;
  int stops = 0;
  int bitc = 0;
  int nrd = 0;
  logic want_addr = 1'b0;
  logic [7:0] msh = 8'h0;
  logic [7:0] addrs [$];
  logic [7:0] wdat [0:7];
  logic [7:0] rbuf [0:7];
  realtime last_rise = 0.0;
  realtime min_per = 1.0e9;

  always #12.5 mclk = ~mclk;

  ranging_host_ctrl #(.PRST(PRST_T)) dut (
    .mclk(mclk), .reset(reset), .ce(ce), .req_valid(req_valid), .req(req),
    .wr_valid(wr_valid), .wr_data(wr_data), .comms_enable(comms_enable),
    .port_reset_req(port_reset_req), .sda_i(sda_w), .req_ready(req_ready),
    .wr_taken(wr_taken), .rd_valid(rd_valid), .rd_data(rd_data), .xfer_done(xfer_done),
    .xfer_nack(xfer_nack), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .port_rst(port_rst), .low_power_comms_gate(low_power_comms_gate)
  );

  sensor_target_model target (
    .scl(scl_w), .sda(sda_w), .gate(low_power_comms_gate), .port_rst(port_rst),
    .refuse(refuse), .pull(t_pull), .idx(idx_m)
  );

  // Wire watcher: framing, first byte after each start, fastest clock period
  always @(negedge sda_w) begin
    if (scl_w === 1'b1) begin
      starts++;
      bitc = 0;
      want_addr = 1'b1;
    end
  end
  always @(posedge sda_w) begin
    if (scl_w === 1'b1) begin
      stops++;
    end
  end
  always @(posedge scl_w) begin
    if (last_rise > 0.0 && $realtime - last_rise < min_per) begin
      min_per = $realtime - last_rise;
    end
    last_rise = $realtime;
    msh = {msh[6:0], sda_w};
    bitc = (bitc == 8) ? 0 : bitc + 1;
    if (bitc == 8 && want_addr) begin
      addrs.push_back(msh);
      want_addr = 1'b0;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      checks++;
      if (got !== exp) begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task automatic print_verdict();
    begin
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask

  // Runs one message; data bytes come from wdat, read bytes land in rbuf
  task automatic xfer(input logic rd, input logic [15:0] idx, input int len);
    int k;
    int t;
    begin
      k = 0;
      nrd = 0;
      starts = 0;
      stops = 0;
      addrs.delete();
      @(posedge mclk);
      req_valid <= 1'b1;
      req <= {rd, idx, len[7:0]};
      wr_valid <= !rd && len > 0;
      wr_data <= wdat[0];
      do @(posedge mclk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      for (t = 0; t < 20000 && xfer_done !== 1'b1; t++) begin
        @(posedge mclk);
        if (wr_taken === 1'b1) begin
          k++;
          wr_valid <= k < len;
          wr_data <= wdat[k % 8];
        end
        if (rd_valid === 1'b1) begin
          rbuf[nrd % 8] = rd_data;
          nrd++;
        end
      end
      wr_valid <= 1'b0;
      chk("message done", 16'h1, xfer_done);
    end
  endtask

  task automatic t_idle();
    begin
      chk("clock line idle", 16'h1, scl_oe_n);
      chk("data line idle", 16'h1, sda_oe_n);
      chk("gate pin", 16'h1, low_power_comms_gate);
      chk("ready", 16'h1, req_ready);
      chk("pad drive level", 16'h0, 16'({scl_o, sda_o}));
    end
  endtask

  task automatic t_port_reset();
    int n;
    int i;
    begin
      n = 0;
      port_reset_req <= 1'b1;
      @(posedge mclk);
      port_reset_req <= 1'b0;
      // Clock enable low for three edges mid-pulse must stretch the pulse by three
      for (i = 0; i < PRST_T + 10; i++) begin
        ce <= !(i >= 2 && i < 5);
        @(posedge mclk);
        n = n + ((port_rst === 1'b1) ? ((req_ready === 1'b0) ? 1 : 100) : 0);
      end
      chk("port reset width", 16'(PRST_T + 3), 16'(n));
    end
  endtask

  task automatic t_write_read();
    int k;
    begin
      wdat[0] = 8'hA5;
      wdat[1] = 8'h3C;
      wdat[2] = 8'hF0;
      xfer(1'b0, 16'h12FE, 3);
      chk("write refused", 16'h0, xfer_nack);
      chk("write address", 16'h52, 16'(addrs.size() > 0 ? addrs[0] : 8'h0));
      chk("write starts", 16'h1, 16'(starts));
      chk("write stops", 16'h1, 16'(stops));
      chk("index after write", 16'h1301, idx_m);
      xfer(1'b1, 16'h12FE, 3);
      chk("read starts", 16'h2, 16'(starts));
      chk("read addresses", 16'h5253, 16'(addrs.size() > 1 ? {addrs[0], addrs[1]} : 16'h0));
      chk("bytes read", 16'h3, 16'(nrd));
      for (k = 0; k < 3; k++) begin
        chk("read data", {8'h0, wdat[k]}, {8'h0, rbuf[k]});
      end
      chk("data released", 16'h1, sda_w);
    end
  endtask

  task automatic t_refuse();
    begin
      refuse <= 1'b1;
      wdat[0] = 8'h5A;
      wdat[1] = 8'h77;
      xfer(1'b0, 16'h0040, 2);
      chk("refusal flagged", 16'h1, xfer_nack);
      chk("index held", 16'h0040, idx_m);
      chk("stop after refusal", 16'h1, 16'(stops));
      refuse <= 1'b0;
    end
  endtask

  task automatic t_gate();
    begin
      starts = 0;
      comms_enable <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("gate pin low", 16'h0, low_power_comms_gate);
      req_valid <= 1'b1;
      req <= {1'b0, 16'h0001, 8'h00};
      repeat (20) @(posedge mclk);
      chk("held off", 16'h0, req_ready);
      chk("no message", 16'h0, 16'(starts));
      req_valid <= 1'b0;
      comms_enable <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("gate pin back", 16'h1, low_power_comms_gate);
    end
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    t_idle();
    t_port_reset();
    t_write_read();
    t_refuse();
    t_gate();
    chk("bit period", 16'h1, 16'(min_per >= 999.0));
    print_verdict();
  end
endmodule
